// [src/tcs_pkg.sv]
// Constants, register map and state type for the tracking calibration scheduler.
// Functional notes
// R1: Report controller state code, above three means error.
// R2: Radio on runs enabled calibrations periodically.
// R3: Radio on entry starts every enabled task.
// R4: Task timer expiry sets its pending bit.
// R5: Host reads back all pending bits.
// R6: Many may pend; only pending tasks run.
// R7: Selection uses pending, priority and path availability.
// R8: Lower priority number wins, LO leakage first.
// R9: Same level: oldest completion wins.
// R10: Skip tasks whose paths are unavailable.
// R11: Each selection runs one 500 us batch.
// R12: Pending clears only on coefficient update; the code also clears all pending bits when radio on is left.
// R13: Re-arbitrate after every batch.
// R14: Disrupted batch is discarded, task waits.
// R15: Host grants observation path in 500 us slots.
// R16: Only host grants observation path; none, no run.
// R17: Host may scatter batches over 6 sec.
// R18: Entry makes enabled tasks pending, counters run.
// R19: Force command sets pending, restarts counters.
// R20: Host selects calibrations by ten-bit mask.
// R21: Only mask enabled at entry may start.
// R22: Subset mask pauses or resumes transmit calibrations.
// R23: One batch at a time; idle outside radio on.
package tcs_pkg;
  localparam int NCAL = 10;
  localparam int NGRP = 5;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_STATE   = 8'h00;
  localparam logic [7:0] ADDR_ENABLE  = 8'h04;
  localparam logic [7:0] ADDR_CTRL    = 8'h08;
  localparam logic [7:0] ADDR_PENDING = 8'h0C;
  localparam logic [7:0] ADDR_RESCHED = 8'h10;
  localparam logic [7:0] ADDR_PAUSE   = 8'h14;
  localparam int CTRL_ON_BIT = 0;
  localparam int RESUME_LSB  = 16;
  localparam logic [3:0] SEL_ALL = 4'hA;
  localparam logic [9:0] TX_CAL_MASK  = 10'h0F0;
  localparam logic [9:0] LOL_CAL_MASK = 10'h030;
  localparam logic [9:0] ENABLE_RESET = 10'h000;
  // Channel pairs by priority level, highest first: LO leakage, Tx QEC, ORx QEC, Rx QEC, HD2.
  localparam logic [14:0] GRP_ORDER = 15'h405A;
  localparam logic [31:0] CODE_POWERUP = 32'h0000_0000;
  localparam logic [31:0] CODE_READY   = 32'h0000_0001;
  localparam logic [31:0] CODE_OFF     = 32'h0000_0002;
  localparam logic [31:0] CODE_ON      = 32'h0000_0003;
  localparam logic [31:0] CODE_ERROR   = 32'h0000_0004;
  localparam int CLK_MHZ        = 20;
  localparam int BATCH_TIME_US  = 500;
  localparam int BATCH_CYCLES   = BATCH_TIME_US * CLK_MHZ;
  localparam int PERIOD_TIME_MS = 100;
  localparam int PERIOD_CYCLES  = PERIOD_TIME_MS * 1000 * CLK_MHZ;
  localparam int BATCHES_NEEDED = 4;
  typedef enum logic [2:0] {ST_POWERUP, ST_READY, ST_OFF, ST_ON, ST_ERROR} tcs_state_e;
endpackage

// [src/tcs_period_timer.sv]
// Free-running period timer of one calibration task.
`timescale 1ns/10ps
module tcs_period_timer #(
  parameter int PERIOD = tcs_pkg::PERIOD_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic run,
  input  wire logic restart,
  output logic      expire
);
  localparam int CW = $clog2(PERIOD + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  logic [CW-1:0] cnt_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r  <= '0;
      expire <= 1'b0;
    end
    else
    begin
      expire <= 1'b0;
      if (restart || !run)
        cnt_r <= '0;
      else if (cnt_r == LAST)
      begin
        cnt_r  <= '0;
        expire <= 1'b1;
      end
      else
        cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule

// [src/tcs_scheduler.sv]
// Tracking calibration scheduler with register port, task timers and batch engine.
`timescale 1ns/10ps
module tcs_scheduler #(
  parameter int BATCH_CYCLES   = tcs_pkg::BATCH_CYCLES,
  parameter int PERIOD_CYCLES  = tcs_pkg::PERIOD_CYCLES,
  parameter int BATCHES_NEEDED = tcs_pkg::BATCHES_NEEDED
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic [tcs_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [31:0]               reg_rdata,
  input  wire logic [1:0]                tx_path_on,
  input  wire logic [1:0]                rx_path_on,
  input  wire logic [1:0]                orx_path_on,
  input  wire logic                      obs_granted,
  output logic                           batch_active,
  output logic      [3:0]                batch_task,
  output logic                           coeff_update,
  output logic      [3:0]                coeff_task
);
  localparam int NCAL = tcs_pkg::NCAL;
  localparam int NGRP = tcs_pkg::NGRP;
  localparam int BCW  = $clog2(BATCH_CYCLES + 1);
  localparam int NBW  = $clog2(BATCHES_NEEDED + 1);
  localparam logic [BCW-1:0] BATCH_LAST = BCW'(BATCH_CYCLES - 1);
  localparam logic [BCW-1:0] BATCH_FULL = BCW'(BATCH_CYCLES);
  localparam logic [NBW-1:0] NB_LAST    = NBW'(BATCHES_NEEDED - 1);

  function automatic logic [NCAL-1:0] onehot(input logic [3:0] idx);
    return NCAL'(1) << idx;
  endfunction

  function automatic logic [31:0] state_code(input tcs_pkg::tcs_state_e st);
    case (st)
      tcs_pkg::ST_POWERUP: return tcs_pkg::CODE_POWERUP;
      tcs_pkg::ST_READY:   return tcs_pkg::CODE_READY;
      tcs_pkg::ST_OFF:     return tcs_pkg::CODE_OFF;
      tcs_pkg::ST_ON:      return tcs_pkg::CODE_ON;
      default:             return tcs_pkg::CODE_ERROR;
    endcase
  endfunction

  // Returns {found, pair, channel}; later loop passes are higher priority and win.
  function automatic logic [4:0] pick(input logic [NCAL-1:0] el, input logic [NGRP-1:0] rh);
    logic [4:0] r;
    int         g;
    r = 5'h00;
    for (int p = NGRP - 1; p >= 0; p--)
    begin
      g = int'(tcs_pkg::GRP_ORDER[p*3 +: 3]);
      // R9: oldest completion first
      if (el[2*g] && el[2*g+1])
        r = {1'b1, 3'(g), ~rh[g]};
      else if (el[2*g])
        r = {1'b1, 3'(g), 1'b0};
      else if (el[2*g+1])
        r = {1'b1, 3'(g), 1'b1};
    end
    return r;
  endfunction

  // Path enables arrive from pins and pass two flip-flops.
  logic [6:0] pin_s1_r;
  logic [6:0] pin_s2_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_r <= 7'h00;
      pin_s2_r <= 7'h00;
    end
    else
    begin
      pin_s1_r <= {obs_granted, orx_path_on, rx_path_on, tx_path_on};
      pin_s2_r <= pin_s1_r;
    end
  end

  logic [1:0]      tx_on;
  logic [1:0]      rx_on;
  logic [1:0]      orx_on;
  logic            grant;
  logic [NCAL-1:0] path_ok;

  assign tx_on  = pin_s2_r[1:0];
  assign rx_on  = pin_s2_r[3:2];
  assign orx_on = pin_s2_r[5:4];
  assign grant  = pin_s2_r[6];
  // R16: transmit tasks need the host grant
  assign path_ok = {rx_on, tx_on & {2{grant}}, tx_on & {2{grant}}, orx_on, rx_on};

  logic wr_enable;
  logic wr_ctrl;
  logic wr_resched;
  logic wr_pause;
  logic on_bit;

  assign wr_enable  = reg_wr && (reg_addr == tcs_pkg::ADDR_ENABLE);
  assign wr_ctrl    = reg_wr && (reg_addr == tcs_pkg::ADDR_CTRL);
  assign wr_resched = reg_wr && (reg_addr == tcs_pkg::ADDR_RESCHED);
  assign wr_pause   = reg_wr && (reg_addr == tcs_pkg::ADDR_PAUSE);
  assign on_bit     = reg_wdata[tcs_pkg::CTRL_ON_BIT];

  tcs_pkg::tcs_state_e st_r;
  tcs_pkg::tcs_state_e st_nxt;
  logic                radio_on;
  logic                enter_on;

  // Rewriting the enable mask while radio on is a configuration error; radio off recovers.
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      tcs_pkg::ST_POWERUP: st_nxt = tcs_pkg::ST_READY;
      tcs_pkg::ST_READY,
      tcs_pkg::ST_OFF:
        if (wr_ctrl)
          st_nxt = on_bit ? tcs_pkg::ST_ON : tcs_pkg::ST_OFF;
      tcs_pkg::ST_ON:
        if (wr_enable)
          st_nxt = tcs_pkg::ST_ERROR;
        else if (wr_ctrl && !on_bit)
          st_nxt = tcs_pkg::ST_OFF;
      tcs_pkg::ST_ERROR:
        if (wr_ctrl && !on_bit)
          st_nxt = tcs_pkg::ST_OFF;
      default: st_nxt = tcs_pkg::ST_ERROR;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= tcs_pkg::ST_POWERUP;
    else
      st_r <= st_nxt;
  end

  assign radio_on = (st_r == tcs_pkg::ST_ON);
  assign enter_on = (st_nxt == tcs_pkg::ST_ON) && !radio_on;

  logic [NCAL-1:0] en_r;
  logic [NCAL-1:0] active_en_r;
  logic [NCAL-1:0] paused_r;
  logic [NCAL-1:0] runnable;
  logic [NCAL-1:0] sub_tx;

  assign sub_tx   = reg_wdata[NCAL-1:0] & tcs_pkg::TX_CAL_MASK;
  assign runnable = active_en_r & ~paused_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_r        <= tcs_pkg::ENABLE_RESET;
      active_en_r <= tcs_pkg::ENABLE_RESET;
    end
    else
    begin
      // R20: ten-bit enable mask
      if (wr_enable)
        en_r <= reg_wdata[NCAL-1:0];
      // R21: mask frozen at radio on entry
      if (enter_on)
        active_en_r <= en_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      paused_r <= '0;
    else if (enter_on)
      paused_r <= '0;
    // R22: subset pause and resume
    else if (wr_pause && radio_on)
      paused_r <= (paused_r & ~sub_tx) | (sub_tx & ~reg_wdata[tcs_pkg::RESUME_LSB +: NCAL]);
  end

  logic [NCAL-1:0] force_v;
  logic [NCAL-1:0] expire_v;
  logic [NCAL-1:0] restart_v;
  logic [NCAL-1:0] done_v;
  logic [NCAL-1:0] pending_r;

  // R19: one task or all; a selector beyond the list is ignored
  assign force_v = !(wr_resched && radio_on) ? '0 :
                   (reg_wdata[3:0] == tcs_pkg::SEL_ALL) ? active_en_r :
                   onehot(reg_wdata[3:0]) & active_en_r;
  // R18: entry restarts every timer
  assign restart_v = enter_on ? {NCAL{1'b1}} : force_v;

  // R2: timers only run in radio on
  for (genvar i = 0; i < NCAL; i++)
  begin : g_timer
    tcs_period_timer #(
      .PERIOD (PERIOD_CYCLES)
    ) u_timer (
      .clk     (clk),
      .rst_n   (rst_n),
      .run     (radio_on && active_en_r[i]),
      .restart (restart_v[i]),
      .expire  (expire_v[i])
    );
  end

  // A set in the same cycle as a completion wins, so a fresh request is never lost.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pending_r <= '0;
    // R3: all enabled tasks start at entry
    else if (enter_on)
      pending_r <= en_r;
    else if (!radio_on)
      pending_r <= '0;
    // R4: timer expiry requests service
    else
      pending_r <= (pending_r & ~done_v) | ((expire_v & active_en_r) | force_v);
  end

  logic [NCAL-1:0] eligible;
  logic [4:0]      sel;
  // A cleared history bit means the even channel finished last, so the odd one goes first.
  logic [NGRP-1:0] recent_hi_r;

  // R6 R7 R10: pending, runnable, path available
  assign eligible = pending_r & runnable & path_ok & {NCAL{radio_on}};
  // R8: fixed priority order
  assign sel = pick(eligible, recent_hi_r);

  logic           batch_done_r;
  logic [BCW-1:0] bcnt_r;
  logic           start;
  logic           abort;
  logic           batch_end;
  logic [NBW-1:0] nb_r [NCAL];

  // R13: a new pick only after the previous batch is over
  assign start = !batch_active && sel[4];
  // R14: lost path, pause or leaving radio on drops the batch
  assign abort = batch_active && !eligible[batch_task];
  assign batch_end = batch_active && !abort && (bcnt_r == BATCH_LAST);
  // R12: clear pending on coefficient update
  assign done_v = (batch_end && (nb_r[batch_task] == NB_LAST)) ? onehot(batch_task) : '0;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      batch_active <= 1'b0;
      batch_task   <= 4'h0;
      bcnt_r       <= '0;
    end
    // R23: one batch at a time
    else if (start)
    begin
      batch_active <= 1'b1;
      batch_task   <= sel[3:0];
      bcnt_r       <= '0;
    end
    // R11: fixed length observation batch
    else if (abort || batch_end)
      batch_active <= 1'b0;
    else if (batch_active)
      bcnt_r <= bcnt_r + 1'b1;
  end

  // Partial observations never count, so only whole batches advance a task.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NCAL; i++)
        nb_r[i] <= '0;
    end
    else if (batch_end)
      nb_r[batch_task] <= (nb_r[batch_task] == NB_LAST) ? '0 : nb_r[batch_task] + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      batch_done_r <= 1'b0;
      coeff_update <= 1'b0;
      coeff_task   <= 4'h0;
      recent_hi_r  <= '0;
    end
    else
    begin
      batch_done_r <= batch_end;
      coeff_update <= |done_v;
      if (|done_v)
      begin
        coeff_task                  <= batch_task;
        recent_hi_r[batch_task[3:1]] <= batch_task[0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        // R1: controller state code
        tcs_pkg::ADDR_STATE:   reg_rdata <= state_code(st_r);
        tcs_pkg::ADDR_ENABLE:  reg_rdata <= 32'(en_r);
        tcs_pkg::ADDR_CTRL:    reg_rdata <= 32'(radio_on);
        // R5: pending readback
        tcs_pkg::ADDR_PENDING: reg_rdata <= 32'(pending_r);
        tcs_pkg::ADDR_PAUSE:   reg_rdata <= 32'(runnable);
        default:               reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata <= 32'h0000_0000;
  end

  // Helper counter that only the batch length check reads.
  logic [BCW-1:0] hlp_age_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hlp_age_r <= '0;
    else if (start)
      hlp_age_r <= '0;
    else if (batch_active)
      hlp_age_r <= hlp_age_r + 1'b1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_start;
    !batch_active ##1 batch_active;
  endsequence

  sequence s_entry;
    !radio_on ##1 radio_on;
  endsequence

  AST_CODE_ON: assert property ( // R1
    reg_rd && (reg_addr == tcs_pkg::ADDR_STATE) && radio_on |=> reg_rdata == tcs_pkg::CODE_ON)
    else $error("State code does not read three in radio on.");

  AST_HOLD_OFF: assert property ( // R23
    !radio_on |=> !batch_active)
    else $error("Batch running outside radio on.");

  AST_ENTRY_PEND: assert property ( // R18
    s_entry |-> ((pending_r & active_en_r) == active_en_r))
    else $error("Enabled task not pending at radio on entry.");

  AST_TIMER_SET: assert property ( // R4
    radio_on && !wr_ctrl && |(expire_v & active_en_r) |=> |(pending_r & $past(expire_v)))
    else $error("Timer expiry did not set pending.");

  AST_FORCE_ALL: assert property ( // R19
    wr_resched && radio_on && !wr_ctrl && (reg_wdata[3:0] == tcs_pkg::SEL_ALL)
    |=> ((pending_r & active_en_r) == active_en_r))
    else $error("Force of all calibrations missed a task.");

  AST_CLR_ON_UPDATE: assert property ( // R12
    radio_on && $past(radio_on) && |($past(pending_r) & ~pending_r) |-> coeff_update)
    else $error("Pending cleared without coefficient update.");

  AST_START_PEND: assert property ( // R6
    s_start |-> pending_r[batch_task])
    else $error("Batch started for a task that is not pending.");

  AST_PATH_DROP: assert property ( // R10
    batch_active && !path_ok[batch_task] |=> !batch_active)
    else $error("Batch kept running without its path.");

  AST_GRANT: assert property ( // R16
    s_start |-> (!tcs_pkg::TX_CAL_MASK[batch_task] || $past(grant)))
    else $error("Transmit batch started without observation grant.");

  AST_BATCH_LEN: assert property ( // R11
    batch_done_r |-> hlp_age_r == BATCH_FULL)
    else $error("Completed batch has wrong length.");

  AST_PRIO: assert property ( // R8
    start && |(eligible & tcs_pkg::LOL_CAL_MASK) |-> tcs_pkg::LOL_CAL_MASK[sel[3:0]])
    else $error("LO leakage task passed over.");

  AST_OLDEST: assert property ( // R9
    start && (eligible[5:4] == 2'b11) |-> sel[3:0] == {3'h2, ~recent_hi_r[2]})
    else $error("Same level pick did not favour oldest completion.");

  AST_DISCARD: assert property ( // R14
    abort |=> !batch_done_r && !coeff_update)
    else $error("Disrupted batch was counted.");
endmodule

// [tb/tcs_host_model.sv]
// Host-side model that drives the path enables and the observation grant.
`timescale 1ns/10ps
module tcs_host_model #(
  parameter int MIN_SLOT = 20
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       want_grant,
  input  wire logic [1:0] want_tx,
  input  wire logic [1:0] want_rx,
  input  wire logic [1:0] want_orx,
  output logic      [1:0] tx_path_on,
  output logic      [1:0] rx_path_on,
  output logic      [1:0] orx_path_on,
  output logic            obs_granted
);
  int slot_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_path_on  <= 2'h0;
      rx_path_on  <= 2'h0;
      orx_path_on <= 2'h0;
    end
    else
    begin
      tx_path_on  <= want_tx;
      rx_path_on  <= want_rx;
      orx_path_on <= want_orx;
    end
  end

  // Whole grant slots.
  // Only the host raises the grant, and it is withdrawn only at a slot boundary,
  // so a request to drop it may take up to one slot to show.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      obs_granted <= 1'b0;
      slot_r      <= 0;
    end
    else
    begin
      if (want_grant)
        obs_granted <= 1'b1;
      else if (slot_r == MIN_SLOT - 1)
        obs_granted <= 1'b0;
      slot_r <= (obs_granted && slot_r != MIN_SLOT - 1) ? slot_r + 1 : 0;
    end
  end
endmodule

// [tb/tb_top.sv]
// Self-checking testbench of the tracking calibration scheduler.
`timescale 1ns/10ps
module tb_top;
  localparam int BC = 20;
  localparam int PC = 2000;
  logic        clk         = 1'b0;
  logic        rst_n       = 1'b0;
  logic [7:0]  reg_addr    = 8'h00;
  logic [31:0] reg_wdata   = 32'h0000_0000;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  logic        want_grant  = 1'b0;
  logic [1:0]  want_tx     = 2'h0;
  logic [1:0]  want_rx     = 2'h0;
  logic [1:0]  want_orx    = 2'h0;
  logic [31:0] reg_rdata;
  logic [1:0]  tx_path_on;
  logic [1:0]  rx_path_on;
  logic [1:0]  orx_path_on;
  logic        obs_granted;
  logic        batch_active;
  logic [3:0]  batch_task;
  logic        coeff_update;
  logic [3:0]  coeff_task;
  int          bad_count   = 0;
  int          comparisons = 0;
  int          cyc_n       = 0;
  int          blen        = 0;
  int          t_on        = 0;
  logic [3:0]  q_task[$];
  int          q_len[$];
  logic        q_cu[$];
  logic [3:0]  q_ct[$];
  // With no completion history yet, the odd channel of each pair is taken first.
  logic [3:0]  order_seq [20] = '{4'h3, 4'h3, 4'h5, 4'h5, 4'h4, 4'h4, 4'h7, 4'h7, 4'h6, 4'h6,
                                 4'h2, 4'h2, 4'h1, 4'h1, 4'h0, 4'h0, 4'h9, 4'h9, 4'h8, 4'h8};

  tcs_scheduler #(.BATCH_CYCLES(BC), .PERIOD_CYCLES(PC), .BATCHES_NEEDED(2)) uut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_path_on(tx_path_on), .rx_path_on(rx_path_on),
    .orx_path_on(orx_path_on), .obs_granted(obs_granted), .batch_active(batch_active),
    .batch_task(batch_task), .coeff_update(coeff_update), .coeff_task(coeff_task));

  tcs_host_model #(.MIN_SLOT(BC)) host (
    .clk(clk), .rst_n(rst_n), .want_grant(want_grant), .want_tx(want_tx), .want_rx(want_rx),
    .want_orx(want_orx), .tx_path_on(tx_path_on), .rx_path_on(rx_path_on),
    .orx_path_on(orx_path_on), .obs_granted(obs_granted));

  always #25 clk = ~clk;

  // Every finished or aborted batch is logged with its length and completion flag.
  always @(posedge clk)
  begin
    cyc_n++;
    #1;
    if (batch_active === 1'b1)
      blen++;
    else if (blen > 0)
    begin
      q_task.push_back(batch_task);
      q_len.push_back(blen);
      q_cu.push_back(coeff_update);
      q_ct.push_back(coeff_task);
      blen = 0;
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task cyc;
    @(posedge clk);
    #1;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    check(reg_rdata, e);
  endtask

  task set_paths(input logic g, input logic [1:0] t, input logic [1:0] r, input logic [1:0] o);
    @(posedge clk);
    want_grant <= g;
    want_tx    <= t;
    want_rx    <= r;
    want_orx   <= o;
  endtask

  task q_clear;
    q_task.delete();
    q_len.delete();
    q_cu.delete();
    q_ct.delete();
  endtask

  task wait_rec(input int n);
    int k;
    k = 0;
    while (q_task.size() < n && k < 2000)
    begin
      cyc;
      k++;
    end
    check(32'(q_task.size() >= n), 32'h1);
  endtask

  task wait_idle;
    int k;
    int q;
    k = 0;
    q = 0;
    while (q < 30 && k < 3000)
    begin
      cyc;
      q = (batch_active === 1'b1) ? 0 : q + 1;
      k++;
    end
  endtask

  task t_reset;
    rchk(tcs_pkg::ADDR_STATE, tcs_pkg::CODE_READY);
    rchk(tcs_pkg::ADDR_ENABLE, 32'(tcs_pkg::ENABLE_RESET));
    rchk(tcs_pkg::ADDR_PENDING, 32'h0000_0000);
    rchk(8'h20, 32'h0000_0000);
  endtask

  task t_order;
    int i;
    set_paths(1'b0, 2'h3, 2'h3, 2'h3);
    wr(tcs_pkg::ADDR_ENABLE, 32'h0000_03FF);
    q_clear;
    wr(tcs_pkg::ADDR_CTRL, 32'h0000_0001);
    t_on = cyc_n;
    rchk(tcs_pkg::ADDR_STATE, tcs_pkg::CODE_ON);
    rchk(tcs_pkg::ADDR_CTRL, 32'h0000_0001);
    rchk(tcs_pkg::ADDR_PENDING, 32'h0000_03FF);
    wait_rec(1);
    rchk(tcs_pkg::ADDR_PENDING, 32'h0000_03FF);
    set_paths(1'b1, 2'h3, 2'h3, 2'h3);
    wait_rec(20);
    for (i = 0; i < 20; i++)
    begin
      check(32'(q_task[i]), 32'(order_seq[i]));
      check(32'(q_len[i]), BC);
      check(32'(q_cu[i]), 32'(i % 2));
      if (i % 2 == 1)
        check(32'(q_ct[i]), 32'(order_seq[i]));
    end
    rchk(tcs_pkg::ADDR_PENDING, 32'h0000_0000);
  endtask

  task t_timer;
    int k;
    k = 0;
    while (batch_active !== 1'b1 && k < 3 * PC)
    begin
      cyc;
      k++;
    end
    check(32'((cyc_n - t_on) >= PC - 2 && (cyc_n - t_on) <= PC + 5), 32'h1);
    check(32'(batch_task), 32'h5);
    rchk(tcs_pkg::ADDR_PENDING, 32'h0000_03FF);
    q_clear;
    set_paths(1'b1, 2'h1, 2'h3, 2'h3);
    wait_rec(2);
    check(32'(q_len[0] < BC), 32'h1);
    check(32'(q_cu[0]), 32'h0);
    check(32'(q_task[1]), 32'h4);
    set_paths(1'b1, 2'h3, 2'h3, 2'h3);
    wait_idle;
    rchk(tcs_pkg::ADDR_PENDING, 32'h0000_0000);
  endtask

  task t_resched;
    int          i;
    logic [31:0] e;
    set_paths(1'b0, 2'h0, 2'h0, 2'h0);
    repeat (5) cyc;
    wr(tcs_pkg::ADDR_RESCHED, 32'h0000_000B);
    rchk(tcs_pkg::ADDR_PENDING, 32'h0000_0000);
    e = 32'h0000_0000;
    for (i = 0; i < 9; i++)
    begin
      wr(tcs_pkg::ADDR_RESCHED, 32'(i));
      e[i] = 1'b1;
      rchk(tcs_pkg::ADDR_PENDING, e);
    end
    wr(tcs_pkg::ADDR_RESCHED, 32'(tcs_pkg::SEL_ALL));
    rchk(tcs_pkg::ADDR_PENDING, 32'h0000_03FF);
  endtask

  task t_pause;
    wr(tcs_pkg::ADDR_PAUSE, 32'h0000_00F0);
    rchk(tcs_pkg::ADDR_PAUSE, 32'h0000_030F);
    q_clear;
    set_paths(1'b1, 2'h3, 2'h3, 2'h3);
    wait_rec(1);
    check(32'(q_task[0]), 32'h3);
    wr(tcs_pkg::ADDR_PAUSE, 32'h0010_0010);
    rchk(tcs_pkg::ADDR_PAUSE, 32'h0000_031F);
  endtask

  task t_error;
    wr(tcs_pkg::ADDR_ENABLE, 32'h0000_03FF);
    rchk(tcs_pkg::ADDR_STATE, tcs_pkg::CODE_ERROR);
    wr(tcs_pkg::ADDR_CTRL, 32'h0000_0000);
    rchk(tcs_pkg::ADDR_STATE, tcs_pkg::CODE_OFF);
    rchk(tcs_pkg::ADDR_CTRL, 32'h0000_0000);
    check(32'(batch_active), 32'h0);
    rchk(tcs_pkg::ADDR_PENDING, 32'h0000_0000);
    wr(tcs_pkg::ADDR_RESCHED, 32'(tcs_pkg::SEL_ALL));
    rchk(tcs_pkg::ADDR_PENDING, 32'h0000_0000);
  endtask

  task stop_test;
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset;
    t_order;
    t_timer;
    t_resched;
    t_pause;
    t_error;
    stop_test;
  end

  // The whole sequence needs about 2600 cycles; over seven times that means a hang.
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    stop_test;
  end
endmodule
